// ==== sbfmd_pkg.sv ====
package sbfmd_pkg;

    // ------------------------------------------------------------
    // Register map and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] SBFMD_FAST_MODULE_DISABLE_OFFS = 8'h03;
    localparam logic [7:0] SBFMD_FAST_MODULE_DISABLE_RST = 8'h00;
    localparam int SBFMD_NUM_MODULES = 6;
    localparam logic [5:0] SBFMD_MODULE_MASK = 6'h3f;

    // ------------------------------------------------------------
    // Field positions, one per module
    // ------------------------------------------------------------
    localparam int SBFMD_FLOPPY_BIT = 0;
    localparam int SBFMD_PARALLEL_BIT = 1;
    localparam int SBFMD_SERIAL_B_BIT = 2;
    localparam int SBFMD_SERIAL_A_BIT = 3;
    localparam int SBFMD_MOUSE_BIT = 4;
    localparam int SBFMD_KEYBOARD_BIT = 5;

    // Register layout; the two upper bits are reserved.
    typedef struct packed {
        logic [1:0] reserved;
        logic keyboard_force_off;
        logic mouse_force_off;
        logic serial_port_a_force_off;
        logic serial_port_b_force_off;
        logic parallel_port_force_off;
        logic floppy_ctrl_force_off;
    } sbfmd_disable_t;

    // One register access from the serial bus slave.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sbfmd_req_t;

endpackage : sbfmd_pkg

// ==== sbfmd_gate.sv ====
`timescale 1ns/10ps
// ------------------------------------------------------------
// Per-module effective enable, registered
// ------------------------------------------------------------
module sbfmd_gate
    import sbfmd_pkg::*;
#(
    parameter int WIDTH = SBFMD_NUM_MODULES
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic resetn_i,
    // Controls
    input wire logic [WIDTH-1:0] activate_i,
    input wire logic [WIDTH-1:0] force_off_i,
    // Result
    output logic [WIDTH-1:0] enable_o
);

    // A forced-off module is disabled whatever its activation bit says.
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            enable_o <= '0;
        end else begin
            enable_o <= activate_i & ~force_off_i;
        end
    end

endmodule : sbfmd_gate

// ==== sbfmd_fast_disable.sv ====
`timescale 1ns/10ps
// ------------------------------------------------------------
// Fast module disable register
// ------------------------------------------------------------
module sbfmd_fast_disable
    import sbfmd_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic resetn_i,
    // Register access from the serial bus slave
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    // Activation bits of the six modules
    input wire logic [5:0] activate_i,
    // Effective enables and raw force-off bits
    output logic [5:0] module_enable_o,
    output logic [5:0] force_off_o
);

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    sbfmd_req_t req;
    sbfmd_disable_t disable_reg;
    sbfmd_disable_t disable_next;
    logic hit;

    assign req = '{wr: reg_wr_i, rd: reg_rd_i, addr: reg_addr_i, wdata: reg_wdata_i};
    assign hit = (req.addr == SBFMD_FAST_MODULE_DISABLE_OFFS);

    // Reserved bits are dropped on write so they always read back as zero.
    always_comb begin
        disable_next = disable_reg;
        if (req.wr && hit) begin
            disable_next = sbfmd_disable_t'(req.wdata & {2'b00, SBFMD_MODULE_MASK});
        end
    end

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    // Reset brings every module back under its own activation bit.
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            disable_reg <= sbfmd_disable_t'(SBFMD_FAST_MODULE_DISABLE_RST);
        end else begin
            disable_reg <= disable_next;
        end
    end

    // Mirror of the stored bits toward the modules, for float control.
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            force_off_o <= '0;
        end else begin
            force_off_o <= disable_next[5:0];
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Unmapped offsets answer zero so a stray read never looks like state.
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            reg_rdata_o <= 8'h00;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= req.rd;
            if (req.rd && hit) begin
                reg_rdata_o <= {2'b00, disable_reg[5:0]};
            end else if (req.rd) begin
                reg_rdata_o <= 8'h00;
            end
        end
    end

    // ------------------------------------------------------------
    // Effective enables
    // ------------------------------------------------------------
    // The gate is fed the next disable value so a write bites at the
    // very edge that stores it, with no extra cycle of exposure.
    sbfmd_gate #(
        .WIDTH(SBFMD_NUM_MODULES)
    ) u_gate (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .activate_i(activate_i),
        .force_off_i(disable_next[5:0]),
        .enable_o(module_enable_o)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);

    sequence reg_write_s;
        reg_wr_i && reg_addr_i == SBFMD_FAST_MODULE_DISABLE_OFFS;
    endsequence

    sequence reg_read_s;
        reg_rd_i && reg_addr_i == SBFMD_FAST_MODULE_DISABLE_OFFS && !reg_wr_i;
    endsequence

    reset_clear_a: assert property (@(posedge core_clk_i) disable iff (1'b0)
        !resetn_i |=> force_off_o == 6'h00 && module_enable_o == 6'h00)
        else $error("Register not cleared by reset.");
    write_store_a: assert property (reg_write_s |=> force_off_o == $past(reg_wdata_i[5:0]))
        else $error("Written value not stored.");
    read_back_a: assert property (reg_write_s ##1 reg_read_s
        |=> reg_rvalid_o && reg_rdata_o == {2'b00, $past(reg_wdata_i[5:0], 2)})
        else $error("Read does not return written value with reserved zero.");
    rsvd_zero_a: assert property (reg_rvalid_o |-> reg_rdata_o[7:6] == 2'b00)
        else $error("Reserved bits read non-zero.");
    keyboard_off_a: assert property (force_off_o[SBFMD_KEYBOARD_BIT]
        |-> !module_enable_o[SBFMD_KEYBOARD_BIT])
        else $error("Keyboard enabled while forced off.");
    mouse_off_a: assert property (force_off_o[SBFMD_MOUSE_BIT]
        |-> !module_enable_o[SBFMD_MOUSE_BIT])
        else $error("Mouse enabled while forced off.");
    serial_a_off_a: assert property (force_off_o[SBFMD_SERIAL_A_BIT]
        |-> !module_enable_o[SBFMD_SERIAL_A_BIT])
        else $error("Serial port A enabled while forced off.");
    serial_b_off_a: assert property (force_off_o[SBFMD_SERIAL_B_BIT]
        |-> !module_enable_o[SBFMD_SERIAL_B_BIT])
        else $error("Serial port B enabled while forced off.");
    parallel_off_a: assert property (force_off_o[SBFMD_PARALLEL_BIT]
        |-> !module_enable_o[SBFMD_PARALLEL_BIT])
        else $error("Parallel port enabled while forced off.");
    floppy_off_a: assert property (force_off_o[SBFMD_FLOPPY_BIT]
        |-> !module_enable_o[SBFMD_FLOPPY_BIT])
        else $error("Floppy controller enabled while forced off.");
    enable_follow_a: assert property (resetn_i
        |=> module_enable_o == ($past(activate_i) & ~force_off_o))
        else $error("Enable does not follow activation and disable.");
    write_effect_a: assert property (reg_write_s
        |=> module_enable_o == ($past(activate_i) & ~$past(reg_wdata_i[5:0])))
        else $error("Disable write not effective one cycle later.");

    // ------------------------------------------------------------
    // Checks on the register port
    // ------------------------------------------------------------
    // Any read strobe, mapped or not, is answered exactly once.
    sequence any_read_s;
        reg_rd_i;
    endsequence

    // Accesses to offsets other than the mapped one.
    sequence stray_read_s;
        reg_rd_i && reg_addr_i != SBFMD_FAST_MODULE_DISABLE_OFFS;
    endsequence

    sequence stray_write_s;
        reg_wr_i && reg_addr_i != SBFMD_FAST_MODULE_DISABLE_OFFS;
    endsequence

    // The answer strobe must be a single-cycle pulse, or a slave would
    // take one read twice.
    rvalid_pulse_a: assert property (any_read_s |=> reg_rvalid_o)
        else $error("Read strobe not answered one cycle later.");
    rvalid_only_a: assert property (!reg_rd_i |=> !reg_rvalid_o)
        else $error("Read answer without a read strobe.");
    rdata_hold_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
        else $error("Read data changed without a read.");
    stray_read_a: assert property (stray_read_s |=> reg_rdata_o == 8'h00)
        else $error("Unmapped read returned non-zero data.");
    stray_write_a: assert property (stray_write_s |=> $stable(force_off_o))
        else $error("Unmapped write changed the register.");
    reg_hold_a: assert property (!(reg_wr_i && reg_addr_i == SBFMD_FAST_MODULE_DISABLE_OFFS)
        |=> $stable(force_off_o))
        else $error("Register changed without a write.");
    reset_read_a: assert property (@(posedge core_clk_i) disable iff (1'b0)
        !resetn_i |=> !reg_rvalid_o && reg_rdata_o == 8'h00)
        else $error("Read port not cleared by reset.");

    // ------------------------------------------------------------
    // Checks on each module with its force-off bit clear
    // ------------------------------------------------------------
    // The first cycle after reset is skipped: the enables were still
    // held low there, whatever the activation bits said.
    keyboard_free_a: assert property (resetn_i ##1 !force_off_o[SBFMD_KEYBOARD_BIT]
        |-> module_enable_o[SBFMD_KEYBOARD_BIT] == $past(activate_i[SBFMD_KEYBOARD_BIT]))
        else $error("Keyboard enable does not follow its activation bit.");
    mouse_free_a: assert property (resetn_i ##1 !force_off_o[SBFMD_MOUSE_BIT]
        |-> module_enable_o[SBFMD_MOUSE_BIT] == $past(activate_i[SBFMD_MOUSE_BIT]))
        else $error("Mouse enable does not follow its activation bit.");
    serial_a_free_a: assert property (resetn_i ##1 !force_off_o[SBFMD_SERIAL_A_BIT]
        |-> module_enable_o[SBFMD_SERIAL_A_BIT] == $past(activate_i[SBFMD_SERIAL_A_BIT]))
        else $error("Serial port A enable does not follow its activation bit.");
    serial_b_free_a: assert property (resetn_i ##1 !force_off_o[SBFMD_SERIAL_B_BIT]
        |-> module_enable_o[SBFMD_SERIAL_B_BIT] == $past(activate_i[SBFMD_SERIAL_B_BIT]))
        else $error("Serial port B enable does not follow its activation bit.");
    parallel_free_a: assert property (resetn_i ##1 !force_off_o[SBFMD_PARALLEL_BIT]
        |-> module_enable_o[SBFMD_PARALLEL_BIT] == $past(activate_i[SBFMD_PARALLEL_BIT]))
        else $error("Parallel port enable does not follow its activation bit.");
    floppy_free_a: assert property (resetn_i ##1 !force_off_o[SBFMD_FLOPPY_BIT]
        |-> module_enable_o[SBFMD_FLOPPY_BIT] == $past(activate_i[SBFMD_FLOPPY_BIT]))
        else $error("Floppy enable does not follow its activation bit.");

endmodule : sbfmd_fast_disable

// ==== sbfmd_ctrl_model.sv ====
`timescale 1ns/10ps
// ------------------------------------------------------------
// System controller model on the far side of the register port
// ------------------------------------------------------------
module sbfmd_ctrl_model (
    // Clock
    input wire logic core_clk_i,
    // Byte accesses toward the block
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic [7:0] reg_addr_o,
    output logic [7:0] reg_wdata_o
);
    // Idle strobes low; address and data start at arbitrary junk.
    initial begin
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_addr_o = 8'ha5;
        reg_wdata_o = 8'h5a;
    end

    // One access of one cycle; released lines show the inverse, so stale data never helps.
    task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] data);
        @(negedge core_clk_i);
        reg_wr_o = wr;
        reg_rd_o = ~wr;
        reg_addr_o = addr;
        reg_wdata_o = data;
        @(negedge core_clk_i);
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_addr_o = ~addr;
        reg_wdata_o = ~data;
    endtask : access

    // A write and then a read of the same offset, with no idle cycle between.
    task automatic write_then_read(input logic [7:0] addr, input logic [7:0] data);
        @(negedge core_clk_i);
        reg_wr_o = 1'b1;
        reg_rd_o = 1'b0;
        reg_addr_o = addr;
        reg_wdata_o = data;
        @(negedge core_clk_i);
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b1;
        reg_wdata_o = ~data;
        @(negedge core_clk_i);
        reg_rd_o = 1'b0;
        reg_addr_o = ~addr;
    endtask : write_then_read
endmodule : sbfmd_ctrl_model

// ==== tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
    import sbfmd_pkg::*;
    logic core_clk_i;
    logic resetn_i;
    logic [5:0] activate;
    logic reg_wr, reg_rd, reg_rvalid;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [5:0] module_enable, force_off;
    int fail_count = 0;
    int tests_run = 0;

    // ------------------------------------------------------------
    // Clock, partner and block under test
    // ------------------------------------------------------------
    initial begin
        core_clk_i = 1'b0;
        forever #20 core_clk_i = ~core_clk_i;
    end

    sbfmd_ctrl_model sbfmd_ctrl_model_i (.core_clk_i(core_clk_i), .reg_wr_o(reg_wr),
        .reg_rd_o(reg_rd), .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata));

    sbfmd_fast_disable sbfmd_fast_disable_i (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
        .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
        .reg_rdata_o(reg_rdata), .reg_rvalid_o(reg_rvalid), .activate_i(activate),
        .module_enable_o(module_enable), .force_off_o(force_off));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic test_done();
        $display("Checks run %0d, mismatches %0d.", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : test_done

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Read data is only trusted in the single cycle that rvalid stands.
    task automatic read_check(input logic [7:0] addr, input logic [7:0] exp);
        sbfmd_ctrl_model_i.access(1'b0, addr, 8'h3c);
        check("rvalid", {7'h00, reg_rvalid}, 8'h01);
        if (reg_rvalid !== 1'b1) test_done();
        check("rdata", reg_rdata, exp);
    endtask : read_check

    task automatic write_check(input logic [7:0] data, input logic [5:0] en_exp);
        sbfmd_ctrl_model_i.access(1'b1, SBFMD_FAST_MODULE_DISABLE_OFFS, data);
        check("force_off", {2'b00, force_off}, {2'b00, data[5:0]});
        check("enable", {2'b00, module_enable}, {2'b00, en_exp});
    endtask : write_check

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        read_check(SBFMD_FAST_MODULE_DISABLE_OFFS, 8'h00);
        check("enable_rst", {2'b00, module_enable}, 8'h3f);
    endtask : t_reset

    // Each force-off bit alone must kill exactly its own module.
    task automatic t_each_bit();
        for (int i = 0; i < 6; i++) begin
            write_check(8'h01 << i, 6'h3f & ~(6'h01 << i));
            read_check(SBFMD_FAST_MODULE_DISABLE_OFFS, 8'h01 << i);
        end
    endtask : t_each_bit

    // Reserved bits and an unmapped offset must leave the register alone.
    task automatic t_reserved();
        write_check(8'hff, 6'h00);
        read_check(SBFMD_FAST_MODULE_DISABLE_OFFS, 8'h3f);
        sbfmd_ctrl_model_i.access(1'b1, 8'h04, 8'h00);
        read_check(8'h04, 8'h00);
        read_check(SBFMD_FAST_MODULE_DISABLE_OFFS, 8'h3f);
    endtask : t_reserved

    // With no force-off the activation bits alone decide, one cycle later.
    task automatic t_activate();
        write_check(8'h00, 6'h3f);
        activate = 6'h2a;
        @(negedge core_clk_i);
        check("enable_act", {2'b00, module_enable}, 8'h2a);
        write_check(8'h0a, 6'h20);
    endtask : t_activate

    // A read right behind a write sees the new value; the answer lasts one cycle.
    task automatic t_back_to_back();
        sbfmd_ctrl_model_i.write_then_read(SBFMD_FAST_MODULE_DISABLE_OFFS, 8'he7);
        check("rvalid_b2b", {7'h00, reg_rvalid}, 8'h01);
        check("rdata_b2b", reg_rdata, 8'h27);
        check("enable_b2b", {2'b00, module_enable}, 8'h08);
        @(negedge core_clk_i);
        check("rvalid_drop", {7'h00, reg_rvalid}, 8'h00);
        check("rdata_hold", reg_rdata, 8'h27);
    endtask : t_back_to_back

    // A reset in mid-run must drop every force-off bit again.
    task automatic t_reset_mid();
        @(negedge core_clk_i);
        resetn_i = 1'b0;
        repeat (3) @(negedge core_clk_i);
        resetn_i = 1'b1;
        check("force_off_rst", {2'b00, force_off}, 8'h00);
        check("enable_rst0", {2'b00, module_enable}, 8'h00);
        @(negedge core_clk_i);
        check("enable_rel", {2'b00, module_enable}, {2'b00, activate});
        read_check(SBFMD_FAST_MODULE_DISABLE_OFFS, 8'h00);
    endtask : t_reset_mid

    initial begin
        resetn_i = 1'b0;
        activate = 6'h3f;
        repeat (3) @(negedge core_clk_i);
        resetn_i = 1'b1;
        @(negedge core_clk_i);
        t_reset();
        t_each_bit();
        t_reserved();
        t_activate();
        t_back_to_back();
        t_reset_mid();
        test_done();
    end
endmodule : tb_top
